// ### design/sar_conversion_sequencer.sv
// successive approximation sequencer: clears, runs eight trials, flags completion
// assumes an external comparator answers each trial before the next converter clock tick
// Operation
// R1: each conversion takes exactly eight trials, one result bit each, msb first.
// R2: a rising trigger edge clears the approximation register.
// R3: trials start only after the trigger falls.
// R4: a new trigger pulse abandons the running conversion and restarts it.
// R5: feeding the completion flag back into the trigger gives free-running conversion.
// R6: the outside party should give one external trigger after power-up to start the loop.
// R7: the completion flag falls within zero to eight converter clock pulses of the trigger rise.
// R8: the code boundary N to N+1 sits at ref_lo plus span times (N/256 + 1/512).
// R9: the result register updates one converter clock before the completion flag rises.
// R10: an asynchronous or fast trigger is held high eight clocks plus two microseconds.
// R11: the completion flag rises after the eighth trial and holds until the next trigger rise.
module sar_conversion_sequencer #(
   parameter int unsigned WIDTH = sar_seq_pkg::RESULT_WIDTH
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // converter clock tick and trigger
   input wire logic conv_tick,
   input wire logic conversion_trigger,
   // comparator: high when input is above the trial code boundary
   input wire logic comp_above,
   // comparator side
   output sar_seq_pkg::trial_t trial,
   // host side
   output logic [7:0] result,
   output logic eoc
);

   // the mask, step counter and result are sized for eight bits only; other widths are refused here
   if (WIDTH != sar_seq_pkg::RESULT_WIDTH) begin : g_width_check
      $error("only an 8-bit result is supported");
   end

   // sequencer states; raise gives the one converter tick between result load and flag
   typedef enum logic [2:0] {IDLE, ARMED, TRIAL, PUBLISH, RAISE} state_t;

   // control group
   state_t state;
   state_t next_state;
   logic [7:0] sar;
   logic [7:0] next_sar;
   logic [2:0] step;
   logic [2:0] next_step;
   logic pending;
   logic next_pending;
   // trial group
   sar_seq_pkg::trial_t trial_q;
   sar_seq_pkg::trial_t next_trial;
   // host group
   logic [7:0] result_q;
   logic [7:0] next_result;
   logic eoc_q;
   logic next_eoc;
   // trigger edges and the decoded action of this cycle
   logic trig_rise;
   logic trig_fall;
   logic abort;
   logic present_now;
   logic decide_now;
   logic last_step;
   logic load_result;
   logic raise_flag;

   // one-hot mask for the bit under test
   function automatic logic [7:0] bit_mask(input logic [2:0] idx);
      bit_mask = 8'h01 << idx;
   endfunction

   // trial code: the bits kept so far plus the bit under test
   function automatic logic [7:0] trial_code(input logic [7:0] kept, input logic [2:0] idx);
      trial_code = kept | bit_mask(idx);
   endfunction

   // trigger edges; the detector starts low so an idle trigger gives no false rise after reset
   edge_detect trig_edges (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .level(conversion_trigger),
      .rise(trig_rise),
      .fall(trig_fall)
   );

   // action decode: each converter tick carries at most one step of the conversion
   always_comb begin
      abort = trig_rise;
      present_now = 1'b0;
      decide_now = 1'b0;
      load_result = 1'b0;
      raise_flag = 1'b0;
      last_step = (step == 3'h0);
      if (!abort && conv_tick) begin
         case (state)
            TRIAL: begin
               // two ticks per bit: present the code, then take the comparator's answer
               present_now = !pending;
               decide_now = pending;
            end
            PUBLISH: begin
               load_result = 1'b1;
            end
            RAISE: begin
               raise_flag = 1'b1;
            end
            default: begin
               // ticks are ignored while idle or armed
               present_now = 1'b0;
            end
         endcase
      end
   end

   // control group: state, step counter, present/decide phase, approximation register
   always_comb begin
      next_state = state;
      next_sar = sar;
      next_step = step;
      next_pending = pending;
      if (abort) begin
         // a rise wins over everything in flight: abandon and clear, then wait for the fall [R4]
         next_sar = sar_seq_pkg::SAR_RESET; // [R2]
         next_step = sar_seq_pkg::STEP_RESET;
         next_pending = 1'b0;
         next_state = ARMED;
      end else begin
         case (state)
            IDLE: begin
               // result and flag stand here until the next rise
               next_state = IDLE;
            end
            ARMED: begin
               // with the flag fed back as trigger, its own fall starts the next run [R5]
               if (trig_fall) begin // [R3]
                  next_state = TRIAL;
               end
            end
            TRIAL: begin
               if (present_now) begin
                  next_pending = 1'b1;
               end
               if (decide_now) begin
                  next_pending = 1'b0;
                  // keep the bit when the input lies above the boundary, msb first [R1]
                  if (comp_above) begin
                     next_sar = trial_code(sar, step);
                  end
                  if (last_step) begin
                     next_state = PUBLISH;
                  end else begin
                     next_step = step - 3'h1;
                  end
               end
            end
            PUBLISH: begin
               if (load_result) begin
                  next_state = RAISE;
               end
            end
            RAISE: begin
               if (raise_flag) begin
                  next_state = IDLE;
               end
            end
            default: begin
               next_state = IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= IDLE;
         sar <= sar_seq_pkg::SAR_RESET;
         step <= sar_seq_pkg::STEP_RESET;
         pending <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         sar <= next_sar;
         step <= next_step;
         pending <= next_pending;
      end
   end

   // trial group: the code stands from present to decide, the strobe for one enabled cycle
   always_comb begin
      next_trial = trial_q;
      next_trial.valid = 1'b0;
      if (abort) begin
         // a stale code left by an abandoned run must not reach the comparator [R4]
         next_trial.code = 8'h00;
      end else if (present_now) begin
         // the comparator resolves the half-step boundary of this code [R8]
         next_trial.code = trial_code(sar, step);
         next_trial.valid = 1'b1;
      end else if (decide_now) begin
         next_trial.code = 8'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         trial_q <= '0;
      end else if (clk_en) begin
         trial_q <= next_trial;
      end
   end

   // host group: result register and completion flag
   always_comb begin
      next_result = result_q;
      next_eoc = eoc_q;
      if (abort) begin
         // falls one core cycle after the rise, zero converter pulses, well inside the window [R7]
         next_eoc = 1'b0;
      end else begin
         if (load_result) begin
            next_result = sar; // one converter tick ahead of the flag [R9]
         end
         if (raise_flag) begin
            next_eoc = 1'b1; // held until the next trigger rise [R11]
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         result_q <= sar_seq_pkg::RESULT_RESET;
         eoc_q <= 1'b0;
      end else if (clk_en) begin
         result_q <= next_result;
         eoc_q <= next_eoc;
      end
   end

   // outputs straight from flops
   assign trial = trial_q;
   assign result = result_q;
   assign eoc = eoc_q;

endmodule

// ### design/sar_seq_pkg.sv
// package for the successive approximation sequencer: widths, timing counts, carriers
// assumes a single 25 MHz core clock; the converter clock arrives as a synchronous input
package sar_seq_pkg;

   // result width and number of approximation steps
   localparam int unsigned RESULT_WIDTH = 8;
   localparam int unsigned STEP_COUNT = 8;

   // completion flag must fall within this many converter clock pulses of the trigger rise
   localparam int unsigned EOC_FALL_MAX_PULSES = 8;

   // reset values
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] SAR_RESET = 8'h00;
   localparam logic [2:0] STEP_RESET = 3'h7;

   // code boundary scale: boundary N sits at span*(N/256 + 1/512)
   localparam int unsigned CODE_STEPS = 256;
   localparam int unsigned HALF_STEP_DEN = 512;

   // trial request towards the comparator: code under test and a strobe
   typedef struct packed {
      logic [7:0] code;
      logic valid;
   } trial_t;

   // conversion result towards the host
   typedef struct packed {
      logic [7:0] data;
      logic done;
   } result_t;

endpackage

// ### design/edge_detect.sv
// edge detector for a synchronous level input, gated by a clock enable
// assumes the input is already synchronous to core_clk
module edge_detect (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // sampled level and its edges
   input wire logic level,
   output logic rise,
   output logic fall
);

   logic prev;
   logic next_prev;

   // previous sample
   always_comb begin
      next_prev = level;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prev <= 1'b0;
      end else if (clk_en) begin
         prev <= next_prev;
      end
   end

   // edges only count while enabled, so a frozen block sees none
   assign rise = clk_en & level & ~prev;
   assign fall = clk_en & ~level & prev;

endmodule

// ### verif/comp_model.sv
// comparator model: answers each trial from a level in half steps
// assumes trial.code is never zero when asked
module comp_model (
   // trial and level
   input wire sar_seq_pkg::trial_t trial,
   input wire logic [8:0] vin,
   output logic comp_above
);
   timeunit 1ns;
   timeprecision 1ns;
   // above once the level passes the lower boundary of the code
   assign comp_above = {1'b0, vin} >= {1'b0, trial.code, 1'b0} - 10'h001;
endmodule

// ### verif/sar_seq_checker.sv
// checker for the sequencer ports: trial order, counts, completion flag
// assumes clk_en low freezes the sequencer, so edges and trial counts only advance while it is high
module sar_seq_checker (
   // clock and inputs
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic conversion_trigger,
   // outputs
   input wire sar_seq_pkg::trial_t trial,
   input wire logic [7:0] result,
   input wire logic eoc
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic prv;
   logic [3:0] cnt;
   wire rise = clk_en & conversion_trigger & ~prv;
   // trigger history and trials since the last rise
   always_ff @(posedge core_clk) begin
      prv <= nrst & (clk_en ? conversion_trigger : prv);
      cnt <= (!nrst || rise) ? 4'h0 : cnt + 4'(trial.valid & clk_en);
   end
   sequence s_rise;
      rise;
   endsequence
   a_eoc_drops: assert property (s_rise |=> !eoc) else $error("eoc high");
   a_eoc_holds: assert property (eoc && !rise |=> eoc) else $error("eoc fell");
   a_no_trial: assert property (s_rise |=> !trial.valid) else $error("trial kept");
   a_trial_high: assert property (conversion_trigger && !rise |-> !trial.valid) else $error("early");
   a_code_order: assert property (trial.valid |-> cnt < 8 && 8'(trial.code << cnt) == 8'h80)
      else $error("code");
   a_eight_steps: assert property ($rose(eoc) |-> cnt == 8) else $error("steps");
   a_result_held: assert property (eoc |-> $stable(result)) else $error("result");
   a_valid_pulse: assert property (trial.valid && clk_en |=> !trial.valid) else $error("strobe");
endmodule
bind sar_conversion_sequencer sar_seq_checker chk_inst (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .conversion_trigger(conversion_trigger), .trial(trial), .result(result), .eoc(eoc));

// ### verif/sar_conversion_sequencer_tb.sv
// bench: random conversions, abort, free-running loop
// assumes the comparator model answers at once
module sar_conversion_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, nrst = 0, clk_en = 1, conv_tick = 0, trg = 0, fr = 0, comp_above, eoc;
   logic [7:0] result;
   logic [23:0] snap;
   logic [8:0] vin = 9'h000;
   sar_seq_pkg::trial_t trial;
   int num_errors = 0, checks = 0, cyc = 0;
   wire conversion_trigger = trg | (fr & eoc); // feedback loop, outside pulse still reaches the pin
   sar_conversion_sequencer sar_conversion_sequencer_inst (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .conv_tick(conv_tick), .conversion_trigger(conversion_trigger), .comp_above(comp_above), .trial(trial),
      .result(result), .eoc(eoc));
   comp_model comp_model_inst (.trial(trial), .vin(vin), .comp_above(comp_above));
   initial forever #20 core_clk = ~core_clk;
   // random ticks and hang guard
   always @(posedge core_clk) begin
      conv_tick <= ($urandom % 3) == 0;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         close_out();
      end
   end
   function automatic logic [7:0] want_code(int v);
      int c;
      c = 0;
      for (int b = 7; b >= 0; b--)
         if (v >= 2 * (c | (1 << b)) - 1)
            c = c | (1 << b);
      return 8'(c);
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic pulse(input logic [8:0] v);
      @(posedge core_clk) begin
         trg <= 1'b1;
         vin <= v;
      end
      @(posedge core_clk);
      #1 cmp({7'h00, eoc}, 8'h00);
      @(posedge core_clk) trg <= 1'b0; // synchronous trigger, so two clocks of high suffice
   endtask
   task automatic wait_done();
      for (int n = 0; n < 400 && eoc !== 1'b1; n++)
         @(posedge core_clk) #1;
      cmp({7'h00, eoc}, 8'h01);
      cmp(result, want_code(vin));
   endtask
   task automatic close_out();
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hd0b8));
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      // extremes, then random levels
      for (int i = 0; i < 14; i++) begin
         pulse(i == 0 ? 9'h000 : i == 1 ? 9'h1ff : i == 2 ? 9'h001 : 9'($urandom));
         wait_done();
      end
      // restart mid conversion with a new level
      pulse(9'h0aa);
      repeat (20) @(posedge core_clk);
      pulse(9'h155);
      wait_done();
      // freeze mid conversion: enable low stops every output, the result still comes out right
      pulse(9'h0c7);
      repeat (12) @(posedge core_clk);
      clk_en <= 1'b0;
      #1 snap = {trial.code, result, 6'h00, trial.valid, eoc};
      repeat (25) @(posedge core_clk);
      clk_en <= 1'b1;
      #1 cmp(trial.code, snap[23:16]);
      cmp(result, snap[15:8]);
      cmp({6'h00, trial.valid, eoc}, snap[7:0]);
      wait_done();
      // power up again with the loop wired: it stays idle until one outside pulse
      @(posedge core_clk) begin
         nrst <= 1'b0;
         fr <= 1'b1;
      end
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (10) @(posedge core_clk);
      #1 cmp(result, sar_seq_pkg::RESULT_RESET);
      cmp({7'h00, eoc}, 8'h00);
      pulse(9'($urandom));
      repeat (3) begin
         wait_done();
         repeat (2) @(posedge core_clk);
      end
      close_out();
   end
endmodule
